// >>> rtl/drqlc_top.sv
// drqlc_top: reference qualification timing and first loop controls.
// assumes monitor fail inputs on clk_i, strap pins asynchronous.
//
// Functional notes
// - loss-delay code picks disqualify delay 0.5ms..64s
// - code zero disqualifies after minimum delay
// - requalify after delay times 2,4,16,32
// - buildout bit clear absorbs switch phase difference
// - buildout bit set realigns to new phase
// - buildout resets 0 only hitless high, follower low
// - bandwidth field decodes six rates plus fast lock
// - cap bandwidth for 2 kHz and 8 kHz references
// - bandwidth resets fast lock or 890 Hz by strap
// - slope field limits phase slope, 11 unlimited
// - return-to-preferred bit selects revertive switching
// - free-run offset applied only while enable set
// - holdover smoothing field bypass or three bandwidths
// - smoothing resets 00 or 01 by follower strap
// - per-reference masks block monitor fail indications
`timescale 1ns/10ps
`default_nettype none
module drqlc_top #(
   parameter int TICK_CYCLES = drqlc_pkg::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic hitless_strap_pin_i,
   input wire logic follower_strap_pin_i,
   input wire logic [drqlc_pkg::NUM_REFS-1:0] coarse_frequency_monitor_i,
   input wire logic [drqlc_pkg::NUM_REFS-1:0] single_cycle_monitor_i,
   input wire drqlc_pkg::drqlc_rate_t sel_ref_rate_i,
   output logic [drqlc_pkg::NUM_REFS-1:0] ref_usable_o,
   output drqlc_pkg::drqlc_loop_cfg_t loop_cfg_o
);
   localparam int NR = drqlc_pkg::NUM_REFS;
   localparam int UW = drqlc_pkg::UNIT_W;

   logic [7:0] mask0;
   logic [7:0] mask1;
   logic [7:0] qual;
   logic [7:0] loop0;
   logic [7:0] loop1;
   logic [7:0] next_mask0;
   logic [7:0] next_mask1;
   logic [7:0] next_qual;
   logic [7:0] next_loop0;
   logic [7:0] next_loop1;
   logic [7:0] next_rdata;
   logic [1:0] straps;
   logic hitless_s;
   logic follower_s;
   drqlc_pkg::drqlc_state_t state;
   drqlc_pkg::drqlc_state_t next_state;
   logic [1:0] settle;
   logic [1:0] next_settle;
   drqlc_pkg::drqlc_loop_cfg_t next_cfg;
   logic [3:0] loss_code;
   logic [1:0] acc_code;
   logic [UW-1:0] disq_units;
   logic [UW-1:0] qual_units;
   logic fast;
   logic [2*NR-1:0] masks;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // disqualify delay in 0.5 ms units
   function automatic logic [16:0] delay_units(input logic [3:0] code);
      logic [16:0] u;
      u = 17'h00001;
      case (code)
         4'h0: u = 17'h00001;
         4'h1: u = 17'h00001;
         4'h2: u = 17'h00002;
         4'h3: u = 17'h0000A;
         4'h4: u = 17'h00014;
         4'h5: u = 17'h00064;
         4'h6: u = 17'h000C8;
         4'h7: u = 17'h003E8;
         4'h8: u = 17'h007D0;
         4'h9: u = 17'h00FA0;
         4'hA: u = 17'h01388;
         4'hB: u = 17'h01F40;
         4'hC: u = 17'h03E80;
         4'hD: u = 17'h07D00;
         4'hE: u = 17'h0FA00;
         default: u = 17'h1F400;
      endcase
      return u;
   endfunction : delay_units

   function automatic logic [2:0] acc_shift(input logic [1:0] code);
      logic [2:0] s;
      case (code)
         2'h0: s = 3'h1;
         2'h1: s = 3'h2;
         2'h2: s = 3'h4;
         default: s = 3'h5;
      endcase
      return s;
   endfunction : acc_shift

   function automatic drqlc_pkg::drqlc_ebw_t eff_bw(
      input logic [2:0] code, input drqlc_pkg::drqlc_rate_t rate);
      drqlc_pkg::drqlc_ebw_t b;
      case (code)
         3'h0: b = drqlc_pkg::EBW_0P1;
         3'h1: b = drqlc_pkg::EBW_1P7;
         3'h2: b = drqlc_pkg::EBW_3P5;
         3'h3: b = drqlc_pkg::EBW_14;
         3'h4: b = drqlc_pkg::EBW_28;
         3'h5: b = drqlc_pkg::EBW_890;
         default: b = drqlc_pkg::EBW_7;
      endcase
      if (rate == drqlc_pkg::RATE_2K && (code == drqlc_pkg::BW_28 ||
          code == drqlc_pkg::BW_890)) begin
         b = drqlc_pkg::EBW_14;
      end else if (rate == drqlc_pkg::RATE_8K &&
                   code == drqlc_pkg::BW_890) begin
         b = drqlc_pkg::EBW_56;
      end
      return b;
   endfunction : eff_bw

   // ------------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------------
   drqlc_sync2 #(
      .W(2)
   ) u_strap_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i({hitless_strap_pin_i, follower_strap_pin_i}),
      .q_o(straps)
   );
   assign hitless_s = straps[1];
   assign follower_s = straps[0];

   always_comb begin
      next_state = state;
      next_settle = settle;
      case (state)
         drqlc_pkg::ST_SETTLE: begin
            next_settle = settle + 1'b1;
            if (settle == drqlc_pkg::STRAP_SETTLE) begin
               next_state = drqlc_pkg::ST_LOAD;
            end
         end
         drqlc_pkg::ST_LOAD: next_state = drqlc_pkg::ST_RUN;
         drqlc_pkg::ST_RUN: next_state = drqlc_pkg::ST_RUN;
         default: next_state = drqlc_pkg::ST_SETTLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= drqlc_pkg::ST_SETTLE;
         settle <= 2'h0;
      end else begin
         state <= next_state;
         settle <= next_settle;
      end
   end

   // ------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------
   always_comb begin
      next_mask0 = mask0;
      next_mask1 = mask1;
      next_qual = qual;
      next_loop0 = loop0;
      next_loop1 = loop1;
      if (wr_i) begin
         case (addr_i)
            drqlc_pkg::ADDR_MASK0: next_mask0 = wdata_i;
            drqlc_pkg::ADDR_MASK1: next_mask1 = wdata_i;
            drqlc_pkg::ADDR_QUAL:
               next_qual[drqlc_pkg::QUAL_RSVD_LSB-1:0] =
                  wdata_i[drqlc_pkg::QUAL_RSVD_LSB-1:0];
            drqlc_pkg::ADDR_LOOP0: next_loop0 = wdata_i;
            drqlc_pkg::ADDR_LOOP1: next_loop1 = wdata_i;
            default: ;
         endcase
      end
      if (state == drqlc_pkg::ST_LOAD) begin
         next_loop0[drqlc_pkg::LOOP0_BUILDOUT] =
            !(hitless_s && !follower_s);
         next_loop0[drqlc_pkg::LOOP0_BW_LSB +: 3] = follower_s ?
            drqlc_pkg::BW_890 : drqlc_pkg::BW_FAST;
         next_loop1[drqlc_pkg::LOOP1_FILT_LSB +: 2] = follower_s ?
            drqlc_pkg::FILT_18M : drqlc_pkg::FILT_BYPASS;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            drqlc_pkg::ADDR_MASK0: next_rdata = mask0;
            drqlc_pkg::ADDR_MASK1: next_rdata = mask1;
            drqlc_pkg::ADDR_QUAL: next_rdata = qual;
            drqlc_pkg::ADDR_LOOP0: next_rdata = loop0;
            drqlc_pkg::ADDR_LOOP1: next_rdata = loop1;
            drqlc_pkg::ADDR_STATUS: next_rdata = ref_usable_o;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mask0 <= drqlc_pkg::RST_MASK;
         mask1 <= drqlc_pkg::RST_MASK;
         qual <= drqlc_pkg::RST_QUAL;
         loop0 <= drqlc_pkg::RST_LOOP0;
         loop1 <= drqlc_pkg::RST_LOOP1;
         rdata_o <= 8'h00;
      end else begin
         mask0 <= next_mask0;
         mask1 <= next_mask1;
         qual <= next_qual;
         loop0 <= next_loop0;
         loop1 <= next_loop1;
         rdata_o <= next_rdata;
      end
   end

   // ------------------------------------------------------------------
   // loop configuration outputs
   // ------------------------------------------------------------------
   always_comb begin
      next_cfg.phase_buildout_select =
         loop0[drqlc_pkg::LOOP0_BUILDOUT];
      next_cfg.bandwidth = eff_bw(loop0[drqlc_pkg::LOOP0_BW_LSB +: 3],
                                  sel_ref_rate_i);
      next_cfg.phase_slope_cap = loop0[drqlc_pkg::LOOP0_SLOPE_LSB +: 2];
      next_cfg.slope_limited = loop0[drqlc_pkg::LOOP0_SLOPE_LSB +: 2] !=
                               drqlc_pkg::SLOPE_UNLIMITED;
      next_cfg.revertive = loop1[drqlc_pkg::LOOP1_REVERT];
      next_cfg.offset_apply = loop1[drqlc_pkg::LOOP1_OFFSET];
      next_cfg.holdover_smoothing_select =
         loop1[drqlc_pkg::LOOP1_FILT_LSB +: 2];
      next_cfg.smoothing_bypass = loop1[drqlc_pkg::LOOP1_FILT_LSB +: 2] ==
                                  drqlc_pkg::FILT_BYPASS;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         loop_cfg_o <= '0;
      end else begin
         loop_cfg_o <= next_cfg;
      end
   end

   // ------------------------------------------------------------------
   // guard soak timers
   // ------------------------------------------------------------------
   assign loss_code = qual[drqlc_pkg::QUAL_LOSS_LSB +: 4];
   assign acc_code = qual[drqlc_pkg::QUAL_ACC_LSB +: 2];
   assign fast = (loss_code == 4'h0);
   assign disq_units = {5'h00, delay_units(loss_code)};
   assign qual_units = disq_units << acc_shift(acc_code);
   assign masks = {mask1, mask0};

   for (genvar i = 0; i < NR; i++) begin : g_ref
      drqlc_guard_soak #(
         .TICK_CYCLES(TICK_CYCLES),
         .CW(UW)
      ) u_soak (
         .clk_i(clk_i),
         .arst_n_i(arst_n_i),
         .fail_i((coarse_frequency_monitor_i[i] && !masks[2*i+1]) ||
                 (single_cycle_monitor_i[i] && !masks[2*i])),
         .fast_i(fast),
         .disq_units_i(disq_units),
         .qual_units_i(qual_units),
         .usable_o(ref_usable_o[i])
      );
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_buildout_strap;
      @(posedge clk_i) disable iff (!arst_n_i)
      state == drqlc_pkg::ST_LOAD |=>
         loop0[0] == !($past(hitless_s) && !$past(follower_s));
   endproperty
   a_buildout_strap: assert property (p_buildout_strap)
      else $error("buildout strap default wrong");

   property p_bw_strap;
      @(posedge clk_i) disable iff (!arst_n_i)
      state == drqlc_pkg::ST_LOAD |=>
         loop0[3:1] == ($past(follower_s) ? 3'h5 : 3'h6);
   endproperty
   a_bw_strap: assert property (p_bw_strap)
      else $error("bandwidth strap default wrong");

   property p_filt_strap;
      @(posedge clk_i) disable iff (!arst_n_i)
      state == drqlc_pkg::ST_LOAD |=>
         loop1[7:6] == {1'b0, $past(follower_s)};
   endproperty
   a_filt_strap: assert property (p_filt_strap)
      else $error("smoothing strap default wrong");

   property p_cap_2k;
      @(posedge clk_i) disable iff (!arst_n_i)
      sel_ref_rate_i == drqlc_pkg::RATE_2K && loop0[3:1] == 3'h5 |=>
         loop_cfg_o.bandwidth == drqlc_pkg::EBW_14;
   endproperty
   a_cap_2k: assert property (p_cap_2k)
      else $error("2 kHz bandwidth cap missing");

   property p_slope;
      @(posedge clk_i) disable iff (!arst_n_i)
      ##1 loop_cfg_o.slope_limited == ($past(loop0[5:4]) != 2'h3);
   endproperty
   a_slope: assert property (p_slope)
      else $error("slope limit flag wrong");

   property p_offset;
      @(posedge clk_i) disable iff (!arst_n_i)
      wr_i && addr_i == 8'h1E ##1 !wr_i |=>
         loop_cfg_o.offset_apply == $past(wdata_i[1], 2)
         && loop_cfg_o.revertive == $past(wdata_i[0], 2);
   endproperty
   a_offset: assert property (p_offset)
      else $error("offset or revertive control did not follow write");

   property p_loss_table;
      @(posedge clk_i) disable iff (!arst_n_i)
      loss_code == 4'hF |-> disq_units == 22'h1F400 && !fast;
   endproperty
   a_loss_table: assert property (p_loss_table)
      else $error("64 s disqualify delay wrong");

   property p_acc_mult;
      @(posedge clk_i) disable iff (!arst_n_i)
      acc_code == 2'h2 |-> qual_units == disq_units * 16;
   endproperty
   a_acc_mult: assert property (p_acc_mult)
      else $error("qualify multiplier wrong");

   property p_read;
      @(posedge clk_i) disable iff (!arst_n_i)
      rd_i && addr_i == 8'h1C |=> rdata_o == $past(qual);
   endproperty
   a_read: assert property (p_read)
      else $error("timing register readback wrong");
endmodule : drqlc_top
`default_nettype wire

// >>> rtl/drqlc_pkg.sv
// drqlc_pkg: constants and types for reference qualification and loop
// control of the first loop.
// assumes a 100 MHz system clock and an 8-bit register port.
`default_nettype none
package drqlc_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_MASK0 = 8'h1A;
   localparam logic [7:0] ADDR_MASK1 = 8'h1B;
   localparam logic [7:0] ADDR_QUAL = 8'h1C;
   localparam logic [7:0] ADDR_LOOP0 = 8'h1D;
   localparam logic [7:0] ADDR_LOOP1 = 8'h1E;
   localparam logic [7:0] ADDR_STATUS = 8'h30;

   localparam logic [7:0] RST_MASK = 8'hFF;
   localparam logic [7:0] RST_QUAL = 8'h1A;
   localparam logic [7:0] RST_LOOP0 = 8'h3D;
   localparam logic [7:0] RST_LOOP1 = 8'h04;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int QUAL_LOSS_LSB = 0;
   localparam int QUAL_ACC_LSB = 4;
   localparam int QUAL_RSVD_LSB = 6;
   localparam int LOOP0_BUILDOUT = 0;
   localparam int LOOP0_BW_LSB = 1;
   localparam int LOOP0_SLOPE_LSB = 4;
   localparam int LOOP1_REVERT = 0;
   localparam int LOOP1_OFFSET = 1;
   localparam int LOOP1_FILT_LSB = 6;

   // ------------------------------------------------------------------
   // field codes
   // ------------------------------------------------------------------
   localparam logic [2:0] BW_14 = 3'h3;
   localparam logic [2:0] BW_28 = 3'h4;
   localparam logic [2:0] BW_890 = 3'h5;
   localparam logic [2:0] BW_FAST = 3'h6;
   localparam logic [1:0] SLOPE_UNLIMITED = 2'h3;
   localparam logic [1:0] FILT_BYPASS = 2'h0;
   localparam logic [1:0] FILT_18M = 2'h1;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int NUM_REFS = 8;
   localparam int UNIT_W = 22;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_US = 500;
   localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      EBW_0P1 = 3'b000,
      EBW_1P7 = 3'b001,
      EBW_3P5 = 3'b010,
      EBW_7 = 3'b011,
      EBW_14 = 3'b100,
      EBW_28 = 3'b101,
      EBW_56 = 3'b110,
      EBW_890 = 3'b111
   } drqlc_ebw_t;

   typedef enum logic [1:0] {
      RATE_OTHER = 2'b00,
      RATE_2K = 2'b01,
      RATE_8K = 2'b10
   } drqlc_rate_t;

   typedef enum logic [1:0] {
      ST_SETTLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_RUN = 2'b10
   } drqlc_state_t;

   typedef struct packed {
      logic phase_buildout_select;
      drqlc_ebw_t bandwidth;
      logic slope_limited;
      logic [1:0] phase_slope_cap;
      logic revertive;
      logic offset_apply;
      logic smoothing_bypass;
      logic [1:0] holdover_smoothing_select;
   } drqlc_loop_cfg_t;

endpackage : drqlc_pkg
`default_nettype wire

// >>> rtl/drqlc_sync2.sv
// drqlc_sync2: two-flop synchroniser for slow pin levels.
// assumes inputs are quasi-static levels such as straps.
`timescale 1ns/10ps
`default_nettype none
module drqlc_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : drqlc_sync2
`default_nettype wire

// >>> rtl/drqlc_guard_soak.sv
// drqlc_guard_soak: per-reference guard soak timer.
// assumes fail_i and limits come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module drqlc_guard_soak #(
   parameter int TICK_CYCLES = drqlc_pkg::TICK_CYCLES,
   parameter int CW = drqlc_pkg::UNIT_W
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic fail_i,
   input wire logic fast_i,
   input wire logic [CW-1:0] disq_units_i,
   input wire logic [CW-1:0] qual_units_i,
   output logic usable_o
);
   localparam int SW = $clog2(TICK_CYCLES) + 1;
   logic [SW-1:0] sub;
   logic [SW-1:0] next_sub;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_usable;
   logic [CW-1:0] limit;
   logic unit;

   // ------------------------------------------------------------------
   // soak counting
   // ------------------------------------------------------------------
   always_comb begin
      next_usable = usable_o;
      next_sub = sub;
      next_cnt = cnt;
      limit = usable_o ? disq_units_i : qual_units_i;
      unit = fast_i || (sub == SW'(TICK_CYCLES - 1));
      if (usable_o == fail_i) begin
         if (unit) begin
            next_sub = '0;
            if ({1'b0, cnt} + 1'b1 >= {1'b0, limit}) begin
               next_usable = !usable_o;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end else begin
            next_sub = sub + 1'b1;
         end
      end else begin
         next_sub = '0;
         next_cnt = '0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         usable_o <= 1'b0;
         sub <= '0;
         cnt <= '0;
      end else begin
         usable_o <= next_usable;
         sub <= next_sub;
         cnt <= next_cnt;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_drop_needs_fail;
      @(posedge clk_i) disable iff (!arst_n_i)
      $fell(usable_o) |-> $past(fail_i);
   endproperty
   a_drop_needs_fail: assert property (p_drop_needs_fail)
      else $error("reference dropped without a failure");

   property p_rise_needs_clean;
      @(posedge clk_i) disable iff (!arst_n_i)
      $rose(usable_o) |-> !$past(fail_i) && !$past(fail_i, 2);
   endproperty
   a_rise_needs_clean: assert property (p_rise_needs_clean)
      else $error("reference requalified too early");

   property p_fast_drop;
      @(posedge clk_i) disable iff (!arst_n_i)
      fast_i && usable_o && fail_i |=> !usable_o;
   endproperty
   a_fast_drop: assert property (p_fast_drop)
      else $error("minimum delay disqualify did not act");
endmodule : drqlc_guard_soak
`default_nettype wire

// >>> sim/tb.sv
// tb: self-checking bench for drqlc_top, register port and guard soak.
// assumes a 100 MHz clock and a tick shortened to 4 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int TICK = 4;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic hitless = 1'b1;
   logic follower = 1'b0;
   logic [7:0] coarse = 8'h00;
   logic [7:0] single = 8'h00;
   drqlc_pkg::drqlc_rate_t rate = drqlc_pkg::RATE_OTHER;
   logic [7:0] usable;
   drqlc_pkg::drqlc_loop_cfg_t cfg;
   int err_count = 0;
   int num_checks = 0;

   drqlc_top #(.TICK_CYCLES(TICK)) i_drqlc_top (
      .clk_i(clk),
      .arst_n_i(arst_n),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .rdata_o(rdata),
      .hitless_strap_pin_i(hitless),
      .follower_strap_pin_i(follower),
      .coarse_frequency_monitor_i(coarse),
      .single_cycle_monitor_i(single),
      .sel_ref_rate_i(rate),
      .ref_usable_o(usable),
      .loop_cfg_o(cfg)
   );

   always #5 clk = ~clk;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_n

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic rd_chk(input string n, input logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(n, e, rdata);
   endtask : rd_chk

   task automatic do_reset(input logic h, input logic f);
      @(posedge clk);
      arst_n <= 1'b0;
      hitless <= h;
      follower <= f;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      wait_n(10);
   endtask : do_reset

   task automatic fail_drv(input logic [7:0] s, input logic [7:0] c);
      @(posedge clk);
      single <= s;
      coarse <= c;
   endtask : fail_drv

   task automatic conclude;
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_reset_vals;
      rd_chk("qual", 8'h1C, 8'h1A);
      rd_chk("loop0", 8'h1D, 8'h3C);
      rd_chk("loop1", 8'h1E, 8'h04);
      rd_chk("mask0", 8'h1A, 8'hFF);
      rd_chk("unmapped", 8'h1F, 8'h00);
      chk("buildout", 8'h00, 8'(cfg.phase_buildout_select));
      chk("bw", 8'(drqlc_pkg::EBW_7), 8'(cfg.bandwidth));
      chk("bypass", 8'h01, 8'(cfg.smoothing_bypass));
      chk("slope_lim", 8'h00, 8'(cfg.slope_limited));
      chk("revert", 8'h00, 8'(cfg.revertive));
      chk("offset", 8'h00, 8'(cfg.offset_apply));
   endtask : t_reset_vals

   task automatic t_straps;
      do_reset(1'b1, 1'b1);
      rd_chk("loop0", 8'h1D, 8'h3B);
      rd_chk("loop1", 8'h1E, 8'h44);
      chk("bw", 8'(drqlc_pkg::EBW_890), 8'(cfg.bandwidth));
      chk("smooth", 8'h01, 8'(cfg.holdover_smoothing_select));
      do_reset(1'b0, 1'b0);
      rd_chk("loop0", 8'h1D, 8'h3D);
   endtask : t_straps

   task automatic t_bandwidth;
      logic [2:0] e[3][7] = '{'{0, 1, 2, 4, 5, 7, 3},
         '{0, 1, 2, 4, 4, 4, 3}, '{0, 1, 2, 4, 5, 6, 3}};
      for (int r = 0; r < 3; r++) begin
         for (int c = 0; c < 7; c++) begin
            rate <= drqlc_pkg::drqlc_rate_t'(r[1:0]);
            reg_wr(8'h1D, {4'h3, c[2:0], c[0]});
            wait_n(2);
            chk("bw", 8'(e[r][c]), 8'(cfg.bandwidth));
            chk("buildout", 8'(c[0]), 8'(cfg.phase_buildout_select));
         end
      end
      for (int s = 0; s < 4; s++) begin
         reg_wr(8'h1D, {2'b00, s[1:0], 4'hC});
         wait_n(2);
         chk("slope_lim", 8'(s != 3), 8'(cfg.slope_limited));
         chk("slope", 8'(s), 8'(cfg.phase_slope_cap));
      end
   endtask : t_bandwidth

   task automatic t_ctrl1;
      for (int f = 0; f < 4; f++) begin
         for (int v = 0; v < 4; v++) begin
            reg_wr(8'h1E, {f[1:0], 4'h1, v[1:0]});
            wait_n(2);
            chk("revert", 8'(v[0]), 8'(cfg.revertive));
            chk("offset", 8'(v[1]), 8'(cfg.offset_apply));
            chk("smooth", 8'(f), 8'(cfg.holdover_smoothing_select));
            chk("bypass", 8'(f == 0), 8'(cfg.smoothing_bypass));
         end
      end
      rd_chk("loop1", 8'h1E, 8'hC7);
      reg_wr(8'h1C, 8'hEF);
      rd_chk("qual_ro", 8'h1C, 8'h2F);
   endtask : t_ctrl1

   task automatic t_soak;
      reg_wr(8'h1C, 8'h01);
      reg_wr(8'h1A, 8'h08);
      wait_n(20);
      chk("usable", 8'hFF, usable);
      fail_drv(8'h01, 8'h02);
      wait_n(2);
      fail_drv(8'h00, 8'h02);
      wait_n(6);
      chk("usable", 8'hFF, usable);
      fail_drv(8'h01, 8'h06);
      wait_n(2);
      chk("usable", 8'hFF, usable);
      wait_n(5);
      chk("usable", 8'hFA, usable);
      fail_drv(8'h00, 8'h00);
      wait_n(5);
      chk("usable", 8'hFA, usable);
      wait_n(7);
      chk("usable", 8'hFF, usable);
      reg_wr(8'h1C, 8'h31);
      fail_drv(8'h01, 8'h00);
      wait_n(7);
      rd_chk("status", 8'h30, 8'hFE);
      fail_drv(8'h00, 8'h00);
      wait_n(115);
      chk("usable", 8'hFE, usable);
      wait_n(20);
      chk("usable", 8'hFF, usable);
      reg_wr(8'h1C, 8'h00);
      fail_drv(8'h01, 8'h00);
      wait_n(3);
      chk("usable", 8'hFE, usable);
      fail_drv(8'h00, 8'h00);
      wait_n(5);
      chk("usable", 8'hFF, usable);
      reg_wr(8'h1C, 8'h03);
      fail_drv(8'h01, 8'h00);
      wait_n(38);
      chk("usable", 8'hFF, usable);
      wait_n(3);
      chk("usable", 8'hFE, usable);
      fail_drv(8'h00, 8'h00);
      wait_n(78);
      chk("usable", 8'hFE, usable);
      wait_n(4);
      chk("usable", 8'hFF, usable);
   endtask : t_soak

   // ------------------------------------------------------------------
   // sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      do_reset(1'b1, 1'b0);
      t_reset_vals();
      t_straps();
      t_bandwidth();
      t_ctrl1();
      t_soak();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule : tb
`default_nettype wire
